// ==== src/mrd_params.svh ====
// constants of the 3d register address decoder
// assumes a 22-bit register window plus one local select bit above it
`ifndef MRD_PARAMS_SVH
`define MRD_PARAMS_SVH
`define MRD_ADDR_W      23
`define MRD_BYTE_LSB    0
`define MRD_IDX_LSB     2
`define MRD_CHIP_LSB    10
`define MRD_WRAP_LSB    14
`define MRD_SWZ_BIT     20
`define MRD_ALT_BIT     21
`define MRD_LOCAL_BIT   22
`define MRD_CTRL_OFS    4'h0
`define MRD_STAT_OFS    4'h4
`define MRD_CTRL_RST    1'h0
`define MRD_CHIP_ALL    4'hF
`define MRD_RESP_OKAY   2'h0
`define MRD_RESP_SLVERR 2'h2
`endif

// ==== src/mrd_pkg.sv ====
// types of the 3d register address decoder
// assumes nothing beyond the params header
package mrd_pkg;
  typedef enum logic [1:0] {MRD_NONE, MRD_UNCOND, MRD_SELECT} mrd_share_type;
  typedef struct packed {
    logic          frame_buffer_unit;
    mrd_share_type share;
    logic          fifo;
    logic [5:0]    width;
  } mrd_attr_type;
  typedef enum {MRD_IDLE, MRD_SYNC, MRD_ISSUE, MRD_RESP} mrd_wstate_type;
endpackage : mrd_pkg

// ==== src/mrd_decode.sv ====
// axi4-lite slave decoding the 3d register window into unit write enables
// assumes the frame-buffer unit answers a read index with data one cycle later
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`include "mrd_params.svh"
`timescale 1ns/100ps
`default_nettype none
module mrd_decode #(
  parameter int          N_TEX    = 1,
  parameter logic [255:0] SYNC_MAP = 256'h0
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`MRD_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`MRD_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [7:0]                  unit_idx,
  output logic [31:0]                 unit_data,
  output logic                        frame_buffer_unit_en,
  output logic [N_TEX-1:0]            texture_unit_en,
  output logic                        unit_alt_map,
  output logic                        unit_wr,
  output logic                        fifo_valid,
  input  wire logic                   fifo_ready,
  input  wire logic                   pipe_idle,
  output logic [7:0]                  rd_idx,
  input  wire logic [31:0]            rd_data
);

  ////////////////////////////////////////////////////////////////////////
  function automatic mrd_pkg::mrd_attr_type attr(input logic [7:0] i);
    mrd_pkg::mrd_attr_type a;
    a = '{frame_buffer_unit: 1'b1, share: mrd_pkg::MRD_NONE, fifo: 1'b1, width: 6'd32};
    if (i <= 8'h01) a.fifo = 1'b0;
    else if (i <= 8'h07 || (i >= 8'h22 && i <= 8'h25))
      a = '{frame_buffer_unit: 1'b1, share: mrd_pkg::MRD_UNCOND, fifo: 1'b1, width: 6'd16};
    else if (i inside {8'h0D, 8'h0E, 8'h15, 8'h16, 8'h1D, 8'h1E})
      a = '{frame_buffer_unit: 1'b0, share: mrd_pkg::MRD_SELECT, fifo: 1'b1, width: 6'd32};
    else if (i inside {8'h0F, 8'h17, 8'h1F, 8'h20})
      a.share = mrd_pkg::MRD_SELECT;
    else if (i inside {[8'h08:8'h0A], 8'h0C, [8'h10:8'h12], 8'h14, [8'h18:8'h1A], 8'h1C})
      a.width = 6'd24;
    if (i >= 8'h22 && i <= 8'h25) a.width = 6'd32;
    return a;
  endfunction : attr

  function automatic logic [31:0] width_mask(input logic [5:0] w);
    return (w >= 6'd32) ? 32'hFFFFFFFF : ((32'h1 << w) - 32'h1);
  endfunction : width_mask

  ////////////////////////////////////////////////////////////////////////
  // write address and data capture, either order
  logic [`MRD_ADDR_W-1:0] awaddr_q;
  logic [31:0]            wdata_q;
  logic [3:0]             wstrb_q;
  logic                   aw_have_q;
  logic                   w_have_q;
  logic                   alias_en_q;
  logic [15:0]            wr_count_q;
  mrd_pkg::mrd_wstate_type wst_q;

  assign s_axi_awready = (wst_q == mrd_pkg::MRD_IDLE) && !aw_have_q;
  assign s_axi_wready  = (wst_q == mrd_pkg::MRD_IDLE) && !w_have_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // field split of the captured address
  logic [7:0]  w_idx;
  logic [3:0]  w_chip;
  logic [3:0]  w_sel;
  logic        w_alt;
  logic        w_local;
  logic        w_bad;
  logic        w_sync;
  mrd_pkg::mrd_attr_type w_attr;
  logic [N_TEX-1:0] w_tex;

  assign w_idx   = awaddr_q[`MRD_IDX_LSB +: 8];
  assign w_chip  = awaddr_q[`MRD_CHIP_LSB +: 4];
  assign w_alt   = awaddr_q[`MRD_ALT_BIT];
  assign w_local = awaddr_q[`MRD_LOCAL_BIT];
  // partial writes would corrupt neighbouring bits, so refuse them
  assign w_bad   = (awaddr_q[`MRD_BYTE_LSB +: 2] != 2'h0) || (wstrb_q != 4'hF);
  assign w_sel   = (w_chip == 4'h0) ? `MRD_CHIP_ALL : w_chip;
  assign w_attr  = attr(w_idx);
  assign w_sync  = SYNC_MAP[w_idx];

  // only implemented texture bits survive; the rest fall off the top
  always_comb
  begin
    w_tex = '0;
    for (int t = 0; t < N_TEX && t < 3; t++)
    begin
      if (w_attr.share == mrd_pkg::MRD_UNCOND) w_tex[t] = 1'b1;
      else if (w_attr.share == mrd_pkg::MRD_SELECT) w_tex[t] = w_sel[t+1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write sequencing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wst_q <= mrd_pkg::MRD_IDLE;
    else
    begin
      unique case (wst_q)
        mrd_pkg::MRD_IDLE:
          if (aw_have_q && w_have_q)
            wst_q <= (w_bad || w_local) ? mrd_pkg::MRD_RESP : mrd_pkg::MRD_SYNC;
        mrd_pkg::MRD_SYNC:
          if (!w_sync || pipe_idle) wst_q <= mrd_pkg::MRD_ISSUE;
        mrd_pkg::MRD_ISSUE:
          if (!fifo_valid || fifo_ready) wst_q <= mrd_pkg::MRD_RESP;
        mrd_pkg::MRD_RESP:
          if (s_axi_bready) wst_q <= mrd_pkg::MRD_IDLE;
      endcase
    end
  end

  assign s_axi_bvalid = (wst_q == mrd_pkg::MRD_RESP);
  assign s_axi_bresp  = w_bad ? `MRD_RESP_SLVERR : `MRD_RESP_OKAY;

  // unit-side payload held stable from entry into the sync state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      unit_idx             <= 8'h0;
      unit_data            <= 32'h0;
      frame_buffer_unit_en <= 1'b0;
      texture_unit_en      <= '0;
      unit_alt_map         <= 1'b0;
    end
    else if (wst_q == mrd_pkg::MRD_IDLE && aw_have_q && w_have_q)
    begin
      unit_idx             <= w_idx;
      unit_data            <= wdata_q;
      frame_buffer_unit_en <= w_attr.frame_buffer_unit & w_sel[0];
      texture_unit_en      <= w_tex;
      unit_alt_map         <= alias_en_q & w_alt;
    end
  end

  logic issue_fifo_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      issue_fifo_q <= 1'b0;
    else if (wst_q == mrd_pkg::MRD_IDLE)
      issue_fifo_q <= w_attr.fifo;
  end

  assign fifo_valid = (wst_q == mrd_pkg::MRD_ISSUE) && issue_fifo_q;
  assign unit_wr    = (wst_q == mrd_pkg::MRD_ISSUE) && !issue_fifo_q;

  ////////////////////////////////////////////////////////////////////////
  // local control and status words
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      alias_en_q <= `MRD_CTRL_RST;
    else if (wst_q == mrd_pkg::MRD_IDLE && aw_have_q && w_have_q && w_local && !w_bad
             && awaddr_q[3:0] == `MRD_CTRL_OFS)
      alias_en_q <= wdata_q[0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wr_count_q <= 16'h0;
    else if (fifo_valid && fifo_ready || unit_wr)
      wr_count_q <= wr_count_q + 16'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // reads: straight to the frame-buffer unit unless the local bit is set, never through the fifo
  logic                   rpend_q;
  logic                   rvalid_q;
  logic                   rlocal_q;
  logic [3:0]             rofs_q;
  logic [5:0]             rwidth_q;
  logic                   rbad_q;
  mrd_pkg::mrd_attr_type  r_attr;

  assign s_axi_arready = !rpend_q && !rvalid_q;
  assign r_attr        = attr(rd_idx);
  assign rd_idx        = s_axi_araddr[`MRD_IDX_LSB +: 8];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rpend_q  <= 1'b0;
      rlocal_q <= 1'b0;
      rofs_q   <= 4'h0;
      rwidth_q <= 6'd32;
      rbad_q   <= 1'b0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rpend_q  <= 1'b1;
      rlocal_q <= s_axi_araddr[`MRD_LOCAL_BIT];
      rofs_q   <= s_axi_araddr[3:0];
      rwidth_q <= r_attr.width;
      rbad_q   <= s_axi_araddr[`MRD_BYTE_LSB +: 2] != 2'h0;
    end
    else
      rpend_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q    <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `MRD_RESP_OKAY;
    end
    else if (rpend_q)
    begin
      rvalid_q    <= 1'b1;
      s_axi_rresp <= rbad_q ? `MRD_RESP_SLVERR : `MRD_RESP_OKAY;
      if (rlocal_q)
        s_axi_rdata <= (rofs_q == `MRD_STAT_OFS) ? {16'h0, wr_count_q}
                                                 : {31'h0, alias_en_q};
      else
        s_axi_rdata <= rd_data & width_mask(rwidth_q);
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_q;

  ////////////////////////////////////////////////////////////////////////
  a_zero_all: assert property (@(posedge aclk) disable iff (!aresetn)
    wst_q == mrd_pkg::MRD_IDLE && aw_have_q && w_have_q
    && awaddr_q[`MRD_CHIP_LSB +: 4] == 4'h0
    && awaddr_q[`MRD_IDX_LSB +: 8] inside {8'h0F, 8'h17, 8'h1F, 8'h20}
    |=> frame_buffer_unit_en && texture_unit_en[0])
    else $error("unit select zero missed a unit");
  a_uncond_tex: assert property (@(posedge aclk) disable iff (!aresetn)
    fifo_valid && unit_idx == 8'h02 |-> texture_unit_en[0])
    else $error("shared register missed texture unit");
  a_tex_only: assert property (@(posedge aclk) disable iff (!aresetn)
    fifo_valid && unit_idx == 8'h0D |-> !frame_buffer_unit_en)
    else $error("texture-only register reached frame buffer");
  a_fbi_only: assert property (@(posedge aclk) disable iff (!aresetn)
    fifo_valid && unit_idx == 8'h08 |-> texture_unit_en == '0)
    else $error("frame buffer register reached texture unit");
  a_direct_path: assert property (@(posedge aclk) disable iff (!aresetn)
    unit_wr |-> unit_idx <= 8'h01 && !fifo_valid)
    else $error("direct write on fifoed register");
  a_sync_wait: assert property (@(posedge aclk) disable iff (!aresetn)
    wst_q == mrd_pkg::MRD_SYNC && SYNC_MAP[unit_idx] && !pipe_idle
    |=> wst_q == mrd_pkg::MRD_SYNC)
    else $error("sync register loaded while pipe busy");
  a_read_lat: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> ##1 s_axi_rvalid)
    else $error("read answer not two cycles after address");
  a_read_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    rpend_q && !rlocal_q && rwidth_q == 6'd16 |=> s_axi_rdata[31:16] == 16'h0)
    else $error("unimplemented read bits not zero");
  a_bad_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    wst_q == mrd_pkg::MRD_IDLE && aw_have_q && w_have_q && w_bad
    |=> s_axi_bvalid && s_axi_bresp == `MRD_RESP_SLVERR && !unit_wr && !fifo_valid)
    else $error("bad write not refused");

endmodule : mrd_decode
`default_nettype wire

// ==== dv/mrd_unit_model.sv ====
// frame-buffer side model: read data, fifo acceptance, pipeline idle
// assumes rd_idx settles before the edge that takes the read address
`timescale 1ns/100ps
`default_nettype none
module mrd_unit_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  rd_idx,
  output logic      [31:0] rd_data,
  input  wire logic        fifo_valid,
  output logic             fifo_ready,
  output logic             pipe_idle,
  input  wire logic        slow,
  input  wire logic        busy
);
  logic [3:0] wait_q;
  ////////////////////////////////////////////////////////////////////////////
  // data follows the index so a wrong index shows in the read value
  always_ff @(posedge aclk)
  begin
    rd_data <= {rd_idx, ~rd_idx, rd_idx, 8'h5A};
  end
  // slow mode stalls acceptance for eight cycles
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !fifo_valid)
      wait_q <= 4'h0;
    else if (!fifo_ready)
      wait_q <= wait_q + 4'h1;
  end
  assign fifo_ready = fifo_valid && (!slow || wait_q == 4'h8);
  assign pipe_idle  = !busy;
endmodule : mrd_unit_model
`default_nettype wire

// ==== dv/mmio_register_address_decode_test.sv ====
// bench for the 3d register address decoder, acting as axi4-lite master
// assumes mrd_unit_model as frame-buffer side and the params header on the path
`include "mrd_params.svh"
`timescale 1ns/100ps
`default_nettype none
module mmio_register_address_decode_test;
  logic        aclk;
  logic        aresetn;
  logic [22:0] awaddr;
  logic [22:0] araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] udata;
  logic [31:0] rd_data;
  logic [31:0] d;
  logic [7:0]  uidx;
  logic [7:0]  rd_idx;
  logic [3:0]  wstrb;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [1:0]  r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        fb_en, tx_en, alt, uwr, fvalid, fready, idle, slow, busy;
  int          miscompares = 0;
  int          checks_done = 0;
  int          n_dir = 0;
  int          n_fifo = 0;
  int          n0;
  ////////////////////////////////////////////////////////////////////////////
  mrd_decode #(.N_TEX(1), .SYNC_MAP(256'h1 << 64)) DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .unit_idx(uidx), .unit_data(udata), .frame_buffer_unit_en(fb_en), .texture_unit_en(tx_en),
    .unit_alt_map(alt), .unit_wr(uwr), .fifo_valid(fvalid), .fifo_ready(fready),
    .pipe_idle(idle), .rd_idx(rd_idx), .rd_data(rd_data));
  mrd_unit_model PARTNER (.aclk(aclk), .aresetn(aresetn), .rd_idx(rd_idx), .rd_data(rd_data),
    .fifo_valid(fvalid), .fifo_ready(fready), .pipe_idle(idle), .slow(slow), .busy(busy));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    if (aresetn && uwr)
      n_dir <= n_dir + 1;
    if (aresetn && fvalid && fready)
      n_fifo <= n_fifo + 1;
  end
  function automatic logic [22:0] ad(input logic a, input logic [3:0] c, input logic [7:0] i);
    return {1'b0, a, 7'h00, c, i, 2'h0};
  endfunction : ad
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  // ready is looked at mid-cycle, where it equals what the next edge samples
  task automatic axi_wr(input logic [22:0] a, input logic [31:0] v, input logic [3:0] s,
                        output logic [1:0] rs);
    logic ah;
    logic wh;
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done)
    begin
      @(negedge aclk);
      ah   = awvalid && awready;
      wh   = wvalid && wready;
      done = bvalid;
      rs   = bresp;
      @(posedge aclk);
      if (ah)
        awvalid <= 1'b0;
      if (wh)
        wvalid <= 1'b0;
      if (done)
        bready <= 1'b0;
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [22:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ah;
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done)
    begin
      @(negedge aclk);
      ah   = arvalid && arready;
      done = rvalid;
      v    = rdata;
      rs   = rresp;
      @(posedge aclk);
      if (ah)
        arvalid <= 1'b0;
      if (done)
        rready <= 1'b0;
    end
  endtask : axi_rd
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    stop_test();
  end
  initial
  begin
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready, slow, busy} = '0;
    aresetn = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(23'h400000, d, r);
    chk("ctrl_rst", 32'h0, d);
    // every unit-select code, with a nonzero wrap field that must be ignored
    for (int c = 0; c < 16; c++)
    begin
      axi_wr(ad(1'b0, 4'(c), 8'h0F) | 23'h054000, 32'hC0DE0000 + c, 4'hF, r);
      chk("fb_en", 32'(c == 0 || c[0]), 32'(fb_en));
      chk("tx_en", 32'(c == 0 || c[1]), 32'(tx_en));
      chk("uidx", 32'h0F, 32'(uidx));
    end
    axi_wr(ad(1'b0, 4'h1, 8'h02), 32'h1, 4'hF, r);
    chk("tx_uncond", 32'h1, 32'(tx_en));
    axi_wr(ad(1'b0, 4'h1, 8'h0D), 32'h2, 4'hF, r);
    chk("tx_select", 32'h0, 32'(tx_en));
    n0 = n_dir;
    axi_wr(ad(1'b0, 4'h1, 8'h01), 32'h12345678, 4'hF, r);
    chk("bresp_ok", 32'(`MRD_RESP_OKAY), 32'(r));
    chk("direct", n0 + 1, n_dir);
    slow <= 1'b1;
    n0 = n_fifo;
    fork
      axi_wr(ad(1'b0, 4'h1, 8'h03), 32'h0000ABCD, 4'hF, r);
      begin
        axi_rd(ad(1'b0, 4'h2, 8'h01), d, r);
        chk("rd_pend", n0, n_fifo);
        chk("rd_fbi", 32'h01FE015A, d);
        chk("rresp_ok", 32'(`MRD_RESP_OKAY), 32'(r));
      end
    join
    chk("fifoed", n0 + 1, n_fifo);
    chk("udata", 32'h0000ABCD, udata);
    slow <= 1'b0;
    axi_rd(ad(1'b0, 4'h0, 8'h08), d, r);
    chk("rd_mask", 32'h00F7085A, d);
    axi_wr(ad(1'b0, 4'h0, 8'h08), 32'h00123456, 4'hF, r);
    chk("fb_only_fb", 32'h1, 32'(fb_en));
    chk("fb_only_tx", 32'h0, 32'(tx_en));
    axi_rd(ad(1'b0, 4'h0, 8'h03), d, r);
    chk("rd_mask16", 32'h0000035A, d);
    busy <= 1'b1;
    n0 = n_dir + n_fifo;
    fork
      axi_wr(ad(1'b0, 4'h1, 8'h40), 32'h5, 4'hF, r);
      begin
        repeat (10) @(posedge aclk);
        chk("sync_hold", n0, n_dir + n_fifo);
        busy <= 1'b0;
      end
    join
    chk("sync_go", n0 + 1, n_dir + n_fifo);
    n0 = n_dir + n_fifo;
    axi_wr(ad(1'b0, 4'h1, 8'h0F) | 23'h1, 32'h7, 4'hF, r);
    chk("bresp_byte", 32'(`MRD_RESP_SLVERR), 32'(r));
    axi_wr(ad(1'b0, 4'h1, 8'h0F), 32'h7, 4'h3, r);
    chk("bresp_strb", 32'(`MRD_RESP_SLVERR), 32'(r));
    axi_rd(ad(1'b0, 4'h1, 8'h01) | 23'h2, d, r);
    chk("rresp_byte", 32'(`MRD_RESP_SLVERR), 32'(r));
    chk("refused", n0, n_dir + n_fifo);
    axi_wr(23'h400000, 32'h1, 4'hF, r);
    axi_wr(ad(1'b1, 4'h1, 8'h0F), 32'h0, 4'hF, r);
    chk("alias_on", 32'h1, 32'(alt));
    axi_wr(23'h400000, 32'h0, 4'hF, r);
    axi_wr(ad(1'b1, 4'h1, 8'h0F), 32'h0, 4'hF, r);
    chk("alias_off", 32'h0, 32'(alt));
    axi_rd(23'h400004, d, r);
    chk("wr_count", n_dir + n_fifo, d);
    stop_test();
  end
endmodule : mmio_register_address_decode_test
`default_nettype wire
